// file: rtl/pciarb_pkg.sv
package pciarb_pkg;
    localparam int PCIARB_NUM_REQ = 5;
    localparam logic [2:0] PCIARB_IDX_CPU = 3'h0;
    localparam logic [2:0] PCIARB_IDX_INIT0 = 3'h1;
    localparam logic [2:0] PCIARB_IDX_INIT1 = 3'h2;
    localparam logic [2:0] PCIARB_IDX_INIT2 = 3'h3;
    localparam logic [2:0] PCIARB_IDX_INIT3 = 3'h4;
    localparam logic [2:0] PCIARB_IDX_NONE = 3'h7;
    localparam logic PCIARB_MODE_EXTERNAL = 1'b0;
    localparam logic PCIARB_MODE_INTERNAL = 1'b1;
    localparam logic [3:0] PCIARB_IDLE_TURNAROUND = 4'h1;
    typedef enum logic [1:0] {PCIARB_RESET, PCIARB_IDLE, PCIARB_GRANT, PCIARB_PARK} pciarb_state_e;
endpackage

// file: rtl/pciarb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pciarb_if;
    logic host_cpu_bus_request_n;
    logic host_cpu_bus_grant_n_o;
    logic host_cpu_bus_grant_n_oe;
    logic initiator0_request_n;
    logic initiator0_grant_n_o;
    logic initiator0_grant_n_oe;
    logic initiator1_request_n;
    logic initiator1_grant_n_o;
    logic initiator1_grant_n_oe;
    logic initiator2_request_n;
    logic initiator3_request_n;
    modport device (
        input host_cpu_bus_request_n, initiator0_request_n, initiator1_request_n,
        input initiator2_request_n, initiator3_request_n,
        output host_cpu_bus_grant_n_o, host_cpu_bus_grant_n_oe,
        output initiator0_grant_n_o, initiator0_grant_n_oe,
        output initiator1_grant_n_o, initiator1_grant_n_oe
    );
    modport host (
        output host_cpu_bus_request_n, initiator0_request_n, initiator1_request_n,
        output initiator2_request_n, initiator3_request_n,
        input host_cpu_bus_grant_n_o, host_cpu_bus_grant_n_oe,
        input initiator0_grant_n_o, initiator0_grant_n_oe,
        input initiator1_grant_n_o, initiator1_grant_n_oe
    );
endinterface
`default_nettype wire

// file: rtl/pciarb_device.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - request high at reset release: internal arbiter
// - request low at reset release: external roles
// - host holds request high during reset for internal mode, low for external
// - cpu request meaningful only in internal mode
// - shared pin: request0 or external grant
// - initiator1 request ignored in external mode
// - cpu grant driven only in internal mode
// - shared output: grant0 or own request
// - shared output: grant1 or resume indication
// - grants float from reset until driven
// - grant chosen from requests and scheme
// - initiator2 requests by driving low
// - initiator3 requests by driving low
module pciarb_device
    import pciarb_pkg::*;
(
    input wire logic clk, // pci clock
    input wire logic rstn, // pci reset, active low
    input wire logic clk_en, // freezes all state when low
    pciarb_if.device bus, // arbiter pins
    input wire logic rotate_en, // scheme: 1 rotating, 0 fixed priority
    input wire logic own_request, // bridge wants bus (external mode)
    input wire logic resume_event, // retry condition cleared (external mode)
    output logic internal_mode_q, // sampled arbiter mode
    output logic own_granted_q // external arbiter grant seen
);
    logic mode_captured_q;
    logic [PCIARB_NUM_REQ-1:0] req_pin_n;
    logic [PCIARB_NUM_REQ-1:0] req_vec;
    logic [PCIARB_NUM_REQ-1:0] gnt_q;
    logic [PCIARB_NUM_REQ-1:0] gnt_d;
    logic [2:0] holder_idx;
    logic [2:0] last_q;
    logic holder_done;
    logic drive_q;
    logic resume_q;
    pciarb_state_e state_q;

    // request pins in grant-vector order: cpu, then initiators 0 to 3
    assign req_pin_n = {bus.initiator3_request_n, bus.initiator2_request_n,
                        bus.initiator1_request_n, bus.initiator0_request_n,
                        bus.host_cpu_bus_request_n};

    // in external mode the cpu and initiator 1 pins mean nothing and the initiator 0 pin
    // is the outside arbiter's grant, so none of them may reach the arbiter
    for (genvar g = 0; g < PCIARB_NUM_REQ; g++) begin : g_req
        assign req_vec[g] = internal_mode_q & ~req_pin_n[g];
    end

    // mode is caught on the first enabled edge after reset release, never under reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_captured_q <= 1'b0;
            internal_mode_q <= PCIARB_MODE_EXTERNAL;
        end else if (clk_en && !mode_captured_q) begin
            mode_captured_q <= 1'b1;
            internal_mode_q <= bus.host_cpu_bus_request_n ? PCIARB_MODE_INTERNAL
                                                          : PCIARB_MODE_EXTERNAL;
        end
    end

    // rotating picks the first requester after the last winner, fixed picks lowest index
    always_comb begin
        logic found;
        int idx;
        gnt_d = '0;
        found = 1'b0;
        idx = 0;
        for (int k = 0; k < PCIARB_NUM_REQ; k++) begin
            idx = rotate_en ? (int'(last_q) + 1 + k) % PCIARB_NUM_REQ : k;
            if (!found && req_vec[idx]) begin
                gnt_d[idx] = 1'b1;
                found = 1'b1;
            end
        end
    end

    // index of the current holder; rotation restarts just past it
    always_comb begin
        holder_idx = last_q;
        for (int k = 0; k < PCIARB_NUM_REQ; k++) begin
            if (gnt_q[k]) begin
                holder_idx = 3'(k);
            end
        end
    end

    // the holder keeps the bus only while its own request line stays low
    assign holder_done = ~(|(gnt_q & req_vec));

    // two dead cycles between owners: the old grant pin is high before a new one falls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= PCIARB_RESET;
        end else if (clk_en) begin
            case (state_q)
                PCIARB_RESET: begin
                    if (mode_captured_q && internal_mode_q) begin
                        state_q <= PCIARB_IDLE;
                    end
                end
                PCIARB_IDLE: begin
                    if (|gnt_d) begin
                        state_q <= PCIARB_GRANT;
                    end
                end
                PCIARB_GRANT: begin
                    if (holder_done) begin
                        state_q <= PCIARB_PARK;
                    end
                end
                PCIARB_PARK: begin
                    state_q <= PCIARB_IDLE;
                end
                default: begin
                    state_q <= PCIARB_RESET;
                end
            endcase
        end
    end

    // a winner is loaded only from idle, so it is never swapped for another in place
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gnt_q <= '0;
        end else if (clk_en) begin
            if (state_q == PCIARB_IDLE) begin
                gnt_q <= gnt_d;
            end else if (state_q != PCIARB_GRANT || holder_done) begin
                gnt_q <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_q <= PCIARB_IDX_CPU;
        end else if (clk_en && state_q == PCIARB_GRANT && holder_done) begin
            last_q <= holder_idx;
        end
    end

    // pins stay floating until the mode is known, so the strap never meets a driven grant
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= 1'b0;
        end else if (clk_en && mode_captured_q) begin
            drive_q <= 1'b1;
        end
    end

    // the resume pulse is registered once before it reaches the pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resume_q <= 1'b0;
        end else if (clk_en) begin
            resume_q <= resume_event && !internal_mode_q;
        end
    end

    // the outside grant arrives on the initiator 0 request pin in external mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            own_granted_q <= 1'b0;
        end else if (clk_en) begin
            own_granted_q <= !internal_mode_q && mode_captured_q && !bus.initiator0_request_n;
        end
    end

    // cpu grant pin: floated under reset and left floating in external mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.host_cpu_bus_grant_n_o <= 1'b1;
            bus.host_cpu_bus_grant_n_oe <= 1'b0;
        end else if (clk_en) begin
            bus.host_cpu_bus_grant_n_oe <= drive_q && internal_mode_q;
            bus.host_cpu_bus_grant_n_o <= ~gnt_q[PCIARB_IDX_CPU];
        end
    end

    // shared pin: initiator 0 grant, or the bridge's own request in external mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.initiator0_grant_n_o <= 1'b1;
            bus.initiator0_grant_n_oe <= 1'b0;
        end else if (clk_en) begin
            bus.initiator0_grant_n_oe <= drive_q;
            bus.initiator0_grant_n_o <= internal_mode_q ? ~gnt_q[PCIARB_IDX_INIT0] : ~own_request;
        end
    end

    // shared pin: initiator 1 grant, or the resume indication in external mode;
    // the resume pulse shows one cycle late, after its own register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.initiator1_grant_n_o <= 1'b1;
            bus.initiator1_grant_n_oe <= 1'b0;
        end else if (clk_en) begin
            bus.initiator1_grant_n_oe <= drive_q;
            bus.initiator1_grant_n_o <= internal_mode_q ? ~gnt_q[PCIARB_IDX_INIT1] : ~resume_q;
        end
    end
endmodule
`default_nettype wire

// file: rtl/pciarb_host.sv
`timescale 1ns/1ps
`default_nettype none
module pciarb_host
    import pciarb_pkg::*;
(
    input wire logic clk, // pci clock
    input wire logic rstn, // pci reset, active low
    input wire logic clk_en, // freezes all state when low
    pciarb_if.host bus, // arbiter pins
    input wire logic want_internal, // hold cpu request high through reset
    input wire logic [PCIARB_NUM_REQ-1:0] user_req, // requests: cpu, init0..3
    input wire logic ext_grant, // external-mode grant to bridge
    output logic [2:0] cur_grant_q, // granted index or none
    output logic bridge_req_q, // bridge's own request seen
    output logic resume_seen_q // resume indication seen
);
    logic strap_done_q;
    logic cpu_req_n_q;

    // the cpu line carries the mode strap through reset and up to the device's first enabled edge
    assign bus.host_cpu_bus_request_n = strap_done_q ? cpu_req_n_q : want_internal;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_q <= 1'b0;
        end else if (clk_en) begin
            strap_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_req_n_q <= 1'b1;
            bus.initiator0_request_n <= 1'b1;
            bus.initiator1_request_n <= 1'b1;
            bus.initiator2_request_n <= 1'b1;
            bus.initiator3_request_n <= 1'b1;
        end else if (clk_en) begin
            cpu_req_n_q <= ~user_req[PCIARB_IDX_CPU];
            bus.initiator0_request_n <= want_internal ? ~user_req[PCIARB_IDX_INIT0] : ~ext_grant;
            bus.initiator1_request_n <= ~user_req[PCIARB_IDX_INIT1];
            bus.initiator2_request_n <= ~user_req[PCIARB_IDX_INIT2];
            bus.initiator3_request_n <= ~user_req[PCIARB_IDX_INIT3];
        end
    end

    // a grant pin counts only while driven; the shared pins change role with the strap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_grant_q <= PCIARB_IDX_NONE;
            bridge_req_q <= 1'b0;
            resume_seen_q <= 1'b0;
        end else if (clk_en) begin
            cur_grant_q <= PCIARB_IDX_NONE;
            if (bus.host_cpu_bus_grant_n_oe && !bus.host_cpu_bus_grant_n_o) begin
                cur_grant_q <= PCIARB_IDX_CPU;
            end else if (want_internal && bus.initiator0_grant_n_oe && !bus.initiator0_grant_n_o) begin
                cur_grant_q <= PCIARB_IDX_INIT0;
            end else if (want_internal && bus.initiator1_grant_n_oe && !bus.initiator1_grant_n_o) begin
                cur_grant_q <= PCIARB_IDX_INIT1;
            end
            bridge_req_q <= !want_internal && bus.initiator0_grant_n_oe && !bus.initiator0_grant_n_o;
            resume_seen_q <= !want_internal && bus.initiator1_grant_n_oe && !bus.initiator1_grant_n_o;
        end
    end
endmodule
`default_nettype wire

// file: tb/pciarb_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pciarb_sva (
    input wire logic clk, // clock
    input wire logic rstn, // reset
    input wire logic clk_en, // enable
    input wire logic host_cpu_bus_request_n, // cpu req
    input wire logic host_cpu_bus_grant_n_o, // cpu gnt
    input wire logic host_cpu_bus_grant_n_oe, // cpu gnt oe
    input wire logic initiator0_request_n, // initiator0_request_n
    input wire logic initiator0_grant_n_o, // initiator0_grant_n
    input wire logic initiator0_grant_n_oe, // initiator0_grant_n oe
    input wire logic initiator1_request_n, // initiator1_request_n
    input wire logic initiator1_grant_n_o, // initiator1_grant_n
    input wire logic initiator1_grant_n_oe, // initiator1_grant_n oe
    input wire logic initiator2_request_n, // initiator2_request_n
    input wire logic initiator3_request_n // initiator3_request_n
);
    logic [1:0] cnt_q;
    logic int_q;
    wire gc = host_cpu_bus_grant_n_oe & ~host_cpu_bus_grant_n_o;
    wire g0 = initiator0_grant_n_oe & ~initiator0_grant_n_o;
    wire g1 = initiator1_grant_n_oe & ~initiator1_grant_n_o;
    wire run_i = (cnt_q == 2'h3) & int_q;
    wire run_e = (cnt_q == 2'h3) & ~int_q;
    wire lone0 = ~initiator0_request_n & host_cpu_bus_request_n & initiator1_request_n
               & initiator2_request_n & initiator3_request_n;
    // mode strap is taken on the first enabled edge; pins drive two edges later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
            int_q <= 1'b0;
        end else if (clk_en && cnt_q != 2'h3) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == 2'h0) int_q <= host_cpu_bus_request_n;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_float; cnt_q != 2'h3 |-> !(gc || initiator0_grant_n_oe || initiator1_grant_n_oe); endproperty
    a_float: assert property (p_float) else $error("grant pin driven before mode settled");
    property p_int_oe; run_i |-> host_cpu_bus_grant_n_oe && initiator0_grant_n_oe && initiator1_grant_n_oe; endproperty
    a_int_oe: assert property (p_int_oe) else $error("grant pin floating in internal mode");
    property p_ext_oe; run_e |-> initiator0_grant_n_oe && initiator1_grant_n_oe && !host_cpu_bus_grant_n_oe; endproperty
    a_ext_oe: assert property (p_ext_oe) else $error("wrong pin drive in external mode");
    property p_onehot; run_i |-> $onehot0({gc, g0, g1}); endproperty
    a_onehot: assert property (p_onehot) else $error("two grants at once");
    property p_gcpu; run_i && gc |-> !$past(host_cpu_bus_request_n, 2) || !$past(host_cpu_bus_request_n, 3); endproperty
    a_gcpu: assert property (p_gcpu) else $error("cpu grant without request");
    property p_g0; run_i && g0 |-> !$past(initiator0_request_n, 2) || !$past(initiator0_request_n, 3); endproperty
    a_g0: assert property (p_g0) else $error("grant0 without request");
    property p_g1; run_i && g1 |-> !$past(initiator1_request_n, 2) || !$past(initiator1_request_n, 3); endproperty
    a_g1: assert property (p_g1) else $error("grant1 without request");
    property p_ans; (run_i && lone0) [*3] |-> ##[0:30] g0; endproperty
    a_ans: assert property (p_ans) else $error("held request0 never granted");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import pciarb_pkg::*; ;
    logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, rotate_en = 1'b0, own_request = 1'b0, resume_event = 1'b0;
    logic want_internal = 1'b1, ext_grant = 1'b0, internal_mode_q, own_granted_q, bridge_req_q, resume_seen_q;
    logic [4:0] user_req = 5'h00;
    logic [2:0] cur_grant_q;
    int failures = 0, cmp_count = 0, n;
    pciarb_if bus();
    pciarb_device pciarb_device_i(.clk, .rstn, .clk_en, .bus(bus), .rotate_en, .own_request, .resume_event,
        .internal_mode_q, .own_granted_q);
    pciarb_host pciarb_host_i(.clk, .rstn, .clk_en, .bus(bus), .want_internal, .user_req, .ext_grant,
        .cur_grant_q, .bridge_req_q, .resume_seen_q);
    pciarb_sva pciarb_sva_i(.clk, .rstn, .clk_en, .host_cpu_bus_request_n(bus.host_cpu_bus_request_n),
        .host_cpu_bus_grant_n_o(bus.host_cpu_bus_grant_n_o), .host_cpu_bus_grant_n_oe(bus.host_cpu_bus_grant_n_oe),
        .initiator0_request_n(bus.initiator0_request_n), .initiator0_grant_n_o(bus.initiator0_grant_n_o),
        .initiator0_grant_n_oe(bus.initiator0_grant_n_oe), .initiator1_request_n(bus.initiator1_request_n),
        .initiator1_grant_n_o(bus.initiator1_grant_n_o), .initiator1_grant_n_oe(bus.initiator1_grant_n_oe),
        .initiator2_request_n(bus.initiator2_request_n), .initiator3_request_n(bus.initiator3_request_n));
    wire [2:0] pins_n = {bus.initiator1_grant_n_o, bus.initiator0_grant_n_o, bus.host_cpu_bus_grant_n_o};
    always #5 clk = ~clk;
    task check(input string nm, input logic [2:0] exp, input logic [2:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task start(input logic m);
        @(negedge clk);
        rstn = 1'b0;
        want_internal = m;
        user_req = 5'h00;
        repeat (16) @(negedge clk);
        check("oe in reset", 3'h0, {bus.host_cpu_bus_grant_n_oe, bus.initiator0_grant_n_oe, bus.initiator1_grant_n_oe});
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        check("mode", {2'h0, m}, {2'h0, internal_mode_q});
    endtask
    task grant(input logic [4:0] r, input logic [2:0] exp);
        user_req = r;
        n = 0;
        while (cur_grant_q !== exp && n < 30) begin
            @(negedge clk);
            n++;
        end
        check("grant index", exp, cur_grant_q);
    endtask
    // polls at the falling edge so a one-cycle registered flag is still seen
    task automatic wait_hi(ref logic s, input string nm);
        for (int k = 0; k < 20 && s !== 1'b1; k++) @(negedge clk);
        check(nm, 3'h1, {2'h0, s});
    endtask
    initial begin
        start(1'b1);
        for (int i = 0; i < 5; i++) begin
            if (i < 3) begin
                grant(5'h01 << i, 3'(i));
                check("grant pin", 3'h0, {2'h0, pins_n[i]});
            end else begin
                // initiators 2 and 3 have no grant pin: their hold shows as a cpu kept waiting
                user_req = 5'h01 << i;
                repeat (4) @(negedge clk);
                user_req = (5'h01 << i) | 5'h01;
                repeat (8) @(negedge clk);
                check("cpu held off", PCIARB_IDX_NONE, cur_grant_q);
                grant(5'h01, PCIARB_IDX_CPU);
            end
            grant(5'h00, PCIARB_IDX_NONE);
        end
        grant(5'h1F, PCIARB_IDX_CPU);
        grant(5'h00, PCIARB_IDX_NONE);
        rotate_en = 1'b1;
        grant(5'h03, PCIARB_IDX_INIT0);
        grant(5'h00, PCIARB_IDX_NONE);
        grant(5'h03, PCIARB_IDX_CPU);
        grant(5'h00, PCIARB_IDX_NONE);
        $display("internal mode tests done");
        start(1'b0);
        user_req = 5'h05;
        repeat (10) @(negedge clk);
        check("ignored requests", PCIARB_IDX_NONE, cur_grant_q);
        clk_en = 1'b0;
        own_request = 1'b1;
        repeat (4) @(negedge clk);
        check("frozen pin", 3'h1, {2'h0, bus.initiator0_grant_n_o});
        clk_en = 1'b1;
        wait_hi(bridge_req_q, "bridge request");
        check("request pin", 3'h0, {2'h0, bus.initiator0_grant_n_o});
        ext_grant = 1'b1;
        wait_hi(own_granted_q, "external grant");
        resume_event = 1'b1;
        @(negedge clk);
        resume_event = 1'b0;
        wait_hi(resume_seen_q, "resume");
        $display("external mode tests done");
        summarize;
    end
    initial begin
        #50000;
        failures++;
        summarize;
    end
endmodule
`default_nettype wire
